// ==== core/dmacc_channel.sv ====
// DMA channel control: control register, pointers, counter, sequencer.
// Assumes a single-beat system bus with a one-cycle done answer and a
// peripheral request from logic on the same clock.
// How it works
// - dummy-write mode adds a source write after each destination write
// - restore bit reloads pointers and counter at the next operation start
// - repeated modes always reload the counter at each repetition
// - only the original count is stored; pointers rebuilt from the tally of finished transfers
// - soft trigger raises a request, cleared by hardware on completion
// - transfers per trigger follow the transfer mode
// - source mode: hold, increment, decrement, or peripheral indirect
// - destination mode uses the same four encodings
// - transfer mode: one-shot, repeated one-shot, continuous, repeated
// - size bit one moves bytes, zero moves 16-bit words
// - channel runs only while its enable bit is one
// - bits 15-13 and 11 read zero; bit 12 kept at zero
`timescale 1ns/10ps
`default_nettype none
module dmacc_channel (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire dmacc_pkg::dmacc_reg_t regs,
  output logic [15:0]                rdata,
  input  wire logic                  periph_req,
  output dmacc_pkg::dmacc_breq_t     breq,
  input  wire logic                  bus_done,
  input  wire logic [15:0]           bus_rdata,
  output logic                       busy,
  output logic                       block_done
);
  import dmacc_pkg::*;

  // ************************************************************
  // Types and signals
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DUMMY,
    ST_STEP
  } dmacc_state_t;

  dmacc_state_t state_ff;
  logic [15:0]  ctrl_ff;
  logic [15:0]  src_ff;
  logic [15:0]  dst_ff;
  logic [15:0]  cnt_ff;
  logic [15:0]  done_ff;
  logic [15:0]  data_ff;
  logic [15:0]  rdata_ff;
  logic         armed_ff;
  logic         bdone_ff;
  logic         fresh_ff;
  logic [15:0]  orig_cnt;
  logic [15:0]  nxt_src;
  logic [15:0]  nxt_dst;
  logic [15:0]  back_src;
  logic [15:0]  back_dst;
  logic         on;
  logic         byte_sz;
  logic         restore;
  logic         repeated;
  logic         continuous;
  logic         start;
  logic         xfer_end;
  logic         last;
  logic         wr_ctrl;
  logic         wr_cnt;
  logic         wr_src;
  logic         wr_dst;
  logic         reload;
  logic         blk_end;

  assign on         = ctrl_ff[BIT_ON];
  assign byte_sz    = ctrl_ff[BIT_SIZE];
  assign restore    = ctrl_ff[BIT_RESTORE];
  assign repeated   = ctrl_ff[POS_XMODE];
  assign continuous = ctrl_ff[POS_XMODE+1];
  assign wr_ctrl    = regs.wr && (regs.addr == OFS_CTRL);
  assign wr_cnt     = regs.wr && (regs.addr == OFS_CNT);
  assign wr_src     = regs.wr && (regs.addr == OFS_SRC);
  assign wr_dst     = regs.wr && (regs.addr == OFS_DST);
  // A request starts a transfer from idle only while enabled
  assign start = on && (state_ff == ST_IDLE) &&
                 (ctrl_ff[BIT_TRIG] || periph_req);
  // A transfer ends after its write (and dummy write, if any)
  assign xfer_end = (state_ff == ST_STEP);
  assign last     = (cnt_ff == 16'h0001);
  // A block ends at the step of its last transfer, or at every
  // transfer in the one-shot modes
  assign blk_end  = xfer_end && (last || !continuous);
  // First start after the counter runs out brings back the saved values
  assign reload   = start && armed_ff;

  // ************************************************************
  // Pointer stepping
  // ************************************************************
  dmacc_step u_src_step (
    .ptr     (src_ff),
    .mode    (ctrl_ff[POS_SMODE+:2]),
    .byte_sz (byte_sz),
    .nxt_ptr (nxt_src)
  );

  dmacc_step u_dst_step (
    .ptr     (dst_ff),
    .mode    (ctrl_ff[POS_DMODE+:2]),
    .byte_sz (byte_sz),
    .nxt_ptr (nxt_dst)
  );

  // Original count captured whenever software loads the counter
  dmacc_hold u_cnt_hold (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .load (wr_cnt),
    .din  (regs.wdata),
    .dout (orig_cnt)
  );

  // Rebuild original pointers: undo the steps already taken.
  // Cheaper than storing both start addresses.
  // Limitation: a pointer rewritten mid-block is rebuilt from its new value.
  always_comb begin
    logic [15:0] span;
    span = byte_sz ? done_ff : {done_ff[14:0], 1'b0};
    case (ctrl_ff[POS_SMODE+:2])
      AM_INC:  back_src = src_ff - span;
      AM_DEC:  back_src = src_ff + span;
      default: back_src = src_ff;
    endcase
    case (ctrl_ff[POS_DMODE+:2])
      AM_INC:  back_dst = dst_ff - span;
      AM_DEC:  back_dst = dst_ff + span;
      default: back_dst = dst_ff;
    endcase
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // Hardware clear of the trigger wins only when no new write sets it.
  // Cleared at the edge the block ends, so an idle cycle with the bit
  // still set cannot start one transfer too many.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_ff <= regs.wdata & CTRL_MASK;
      end else if (blk_end || !on) begin
        ctrl_ff[BIT_TRIG] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  // A cleared enable drops any beat in flight at the next edge; the
  // pointers keep the position of the last completed transfer.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      case (state_ff)
        ST_IDLE:  if (start) state_ff <= ST_READ;
        ST_READ:  if (!on) state_ff <= ST_IDLE;
                  else if (bus_done) state_ff <= ST_WRITE;
        ST_WRITE: if (!on) state_ff <= ST_IDLE;
                  else if (bus_done) state_ff <= ctrl_ff[BIT_DUMMY] ?
                                       ST_DUMMY : ST_STEP;
        ST_DUMMY: if (!on) state_ff <= ST_IDLE;
                  else if (bus_done) state_ff <= ST_STEP;
        ST_STEP:  if (continuous && !last && on) begin
                    state_ff <= ST_READ;
                  end else begin
                    state_ff <= ST_IDLE;
                  end
        default:  state_ff <= ST_IDLE;
      endcase
    end
  end

  // Data latched from the read beat
  always_ff @(posedge clk) begin
    if (rst) begin
      data_ff <= PTR_RESET;
    end else if (ce && state_ff == ST_READ && bus_done) begin
      data_ff <= bus_rdata;
    end
  end

  // ************************************************************
  // Pointers and counter
  // ************************************************************
  // Source pointer: a software load wins over a rebuild or a step
  always_ff @(posedge clk) begin
    if (rst) begin
      src_ff <= PTR_RESET;
    end else if (ce) begin
      if (wr_src) begin
        src_ff <= regs.wdata;
      end else if (reload && restore) begin
        src_ff <= back_src;
      end else if (xfer_end) begin
        src_ff <= nxt_src;
      end
    end
  end

  // Destination pointer: same priority as the source pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      dst_ff <= PTR_RESET;
    end else if (ce) begin
      if (wr_dst) begin
        dst_ff <= regs.wdata;
      end else if (reload && restore) begin
        dst_ff <= back_dst;
      end else if (xfer_end) begin
        dst_ff <= nxt_dst;
      end
    end
  end

  // Counter and the tally of finished transfers used for rebuilding.
  // Repeated modes reload the count even with restore clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= PTR_RESET;
      done_ff <= PTR_RESET;
    end else if (ce) begin
      if (wr_cnt) begin
        cnt_ff  <= regs.wdata;
        done_ff <= PTR_RESET;
      end else if (reload && (restore || repeated)) begin
        cnt_ff  <= orig_cnt;
        done_ff <= PTR_RESET;
      end else if (xfer_end) begin
        cnt_ff  <= cnt_ff - 16'h0001;
        done_ff <= done_ff + 16'h0001;
      end
    end
  end

  // Armed after the transfer that empties the counter; the next start consumes it
  always_ff @(posedge clk) begin
    if (rst) begin
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (reload) begin
        armed_ff <= 1'b0;
      end else if (xfer_end) begin
        armed_ff <= last;
      end
    end
  end

  // Fresh from a counter load until the first transfer completes
  always_ff @(posedge clk) begin
    if (rst) begin
      fresh_ff <= 1'b1;
    end else if (ce) begin
      if (wr_cnt) begin
        fresh_ff <= 1'b1;
      end else if (xfer_end) begin
        fresh_ff <= 1'b0;
      end
    end
  end

  // Block end pulse; repeated modes stay armed for the next request
  always_ff @(posedge clk) begin
    if (rst) begin
      bdone_ff <= 1'b0;
    end else if (ce) begin
      bdone_ff <= blk_end;
    end
  end

  // ************************************************************
  // Bus request
  // ************************************************************
  // Dummy write goes to the source address with the same data
  always_comb begin
    breq         = '0;
    breq.byte_sz = byte_sz;
    breq.wdata   = data_ff;
    case (state_ff)
      ST_READ:  begin
        breq.valid = 1'b1;
        breq.addr  = src_ff;
      end
      ST_WRITE: begin
        breq.valid = 1'b1;
        breq.write = 1'b1;
        breq.addr  = dst_ff;
      end
      ST_DUMMY: begin
        breq.valid = 1'b1;
        breq.write = 1'b1;
        breq.dummy = 1'b1;
        breq.addr  = src_ff;
      end
      default:  breq.addr = PTR_RESET;
    endcase
  end

  assign busy       = (state_ff != ST_IDLE);
  assign block_done = bdone_ff;

  // ************************************************************
  // Register read port
  // ************************************************************
  // Read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= PTR_RESET;
    end else if (ce) begin
      if (regs.rd) begin
        case (regs.addr)
          OFS_CTRL: rdata_ff <= ctrl_ff & CTRL_MASK;
          OFS_SRC:  rdata_ff <= src_ff;
          OFS_DST:  rdata_ff <= dst_ff;
          OFS_CNT:  rdata_ff <= cnt_ff;
          OFS_STAT: rdata_ff <= {13'h0000, fresh_ff, armed_ff, busy};
          default:  rdata_ff <= PTR_RESET;
        endcase
      end else begin
        rdata_ff <= PTR_RESET;
      end
    end
  end

  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ==== core/dmacc_pkg.sv ====
// Package for the DMA channel control block: register map, fields, modes.
// Assumes a 16-bit data bus and a byte-addressed data space.
package dmacc_pkg;

  localparam int          AW             = 16;
  localparam int          DW             = 16;
  // Register offsets (own choice, plain port)
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_SRC        = 4'h1;
  localparam logic [3:0]  OFS_DST        = 4'h2;
  localparam logic [3:0]  OFS_CNT        = 4'h3;
  localparam logic [3:0]  OFS_STAT       = 4'h4;
  // Control field positions
  localparam int          BIT_ON         = 0;
  localparam int          BIT_SIZE       = 1;
  localparam int          POS_XMODE      = 2;
  localparam int          POS_DMODE      = 4;
  localparam int          POS_SMODE      = 6;
  localparam int          BIT_TRIG       = 8;
  localparam int          BIT_RESTORE    = 9;
  localparam int          BIT_DUMMY      = 10;
  // Implemented bits of channel_control: 10..0
  localparam logic [15:0] CTRL_MASK      = 16'h07ff;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [15:0] STEP_BYTE      = 16'h0001;
  localparam logic [15:0] STEP_WORD      = 16'h0002;

  typedef enum logic [1:0] {
    AM_HOLD = 2'h0,
    AM_INC  = 2'h1,
    AM_DEC  = 2'h2,
    AM_PIA  = 2'h3
  } dmacc_amode_t;

  typedef enum logic [1:0] {
    XM_ONE   = 2'h0,
    XM_RONE  = 2'h1,
    XM_CONT  = 2'h2,
    XM_RCONT = 2'h3
  } dmacc_xmode_t;

  // Bus cycle request to the system bus
  typedef struct packed {
    logic          valid;
    logic          write;
    logic          dummy;
    logic          byte_sz;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dmacc_breq_t;

  typedef struct packed {
    logic [3:0]    addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } dmacc_reg_t;

endpackage

// ==== core/dmacc_step.sv ====
// Pointer stepping unit: next pointer value after a completed transfer.
// Assumes the caller applies the result only when a transfer completes.
`timescale 1ns/10ps
`default_nettype none
module dmacc_step (
  input  wire logic [15:0] ptr,
  input  wire logic [1:0]  mode,
  input  wire logic        byte_sz,
  output logic [15:0]      nxt_ptr
);
  import dmacc_pkg::*;

  logic [15:0] step;

  // Byte mode steps by one address unit, word mode by two
  assign step = byte_sz ? STEP_BYTE : STEP_WORD;

  // Hold and peripheral-indirect leave the pointer alone
  always_comb begin
    case (mode)
      AM_INC:  nxt_ptr = ptr + step;
      AM_DEC:  nxt_ptr = ptr - step;
      default: nxt_ptr = ptr;
    endcase
  end
endmodule
`default_nettype wire

// ==== core/dmacc_hold.sv ====
// Small register that holds the value captured at each load strobe.
// Assumes a synchronous active-high reset and a shared clock enable.
`timescale 1ns/10ps
`default_nettype none
module dmacc_hold (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] din,
  output logic [15:0]      dout
);
  import dmacc_pkg::*;

  logic [15:0] val_ff;

  // Captured value, only the original count is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      val_ff <= PTR_RESET;
    end else if (ce && load) begin
      val_ff <= din;
    end
  end

  assign dout = val_ff;
endmodule
`default_nettype wire

// ==== tb/dmacc_channel_properties.sv ====
// Checker for the DMA channel control block, watching its ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dmacc_channel_properties (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire dmacc_pkg::dmacc_reg_t  regs,
  input wire logic [15:0]            rdata,
  input wire logic                   periph_req,
  input wire dmacc_pkg::dmacc_breq_t breq,
  input wire logic                   bus_done,
  input wire logic [15:0]            bus_rdata,
  input wire logic                   busy,
  input wire logic                   block_done
);
  import dmacc_pkg::*;
  // ****************
  // Control shadow
  // ****************
  logic [15:0] ctrl_ff;
  wire logic   ctrl_wr = ce && regs.wr && regs.addr == OFS_CTRL;
  // A control write may abort a beat, so beat checks skip that cycle
  wire logic   live = ce && ctrl_ff[BIT_ON] && !ctrl_wr;
  // Trigger bit is cleared by hardware, so it is never read here
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= 16'h0000;
    end else if (ctrl_wr) begin
      ctrl_ff <= regs.wdata;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_src_done;
    live && breq.valid && !breq.write && bus_done;
  endsequence
  sequence s_dst_done;
    live && breq.valid && breq.write && !breq.dummy && bus_done;
  endsequence
  a_rdata_idle: assert property ($past(ce) && !$past(regs.rd)
    |-> rdata == 16'h0000) else $error("read data outside slot");
  a_ctrl_unimpl: assert property (
    $past(regs.rd) && $past(regs.addr) == OFS_CTRL |-> rdata[15:11] == 5'h00)
    else $error("unimplemented control bits not zero");
  a_size_match: assert property (
    breq.valid && ce |-> breq.byte_sz == ctrl_ff[BIT_SIZE])
    else $error("beat width differs from size bit");
  a_src_then_dst: assert property (
    s_src_done |=> breq.valid && breq.write && !breq.dummy)
    else $error("source read not followed by destination write");
  a_dummy_follow: assert property (s_dst_done |=>
    breq.valid == ctrl_ff[BIT_DUMMY] && (!breq.valid || breq.dummy))
    else $error("dummy write presence wrong");
  a_dummy_gap: assert property (
    live && breq.valid && breq.dummy && bus_done |=> !breq.valid)
    else $error("no step cycle after dummy write");
  a_req_hold: assert property (live && breq.valid && !bus_done
    |=> $stable(breq)) else $error("beat changed before answer");
  a_off_idle: assert property (
    !ctrl_ff[BIT_ON] && !$past(ctrl_ff[BIT_ON]) |-> ##1 !busy)
    else $error("channel busy while disabled");
  a_done_pulse: assert property (
    block_done |-> !$past(breq.valid) && $past(busy) ##1 !block_done)
    else $error("block end pulse misplaced");
  a_start_soon: assert property (
    live && !busy && periph_req |-> ##[1:2] breq.valid)
    else $error("request not started");
endmodule
`default_nettype wire

// ==== tb/dmacc_bus_model.sv ====
// System bus model: answers each beat promptly or after three waits.
// Assumes beats are held until bus_done, as the channel promises.
`timescale 1ns/10ps
`default_nettype none
module dmacc_bus_model (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire dmacc_pkg::dmacc_breq_t breq,
  input  wire logic                   slow,
  output logic                        bus_done,
  output logic [15:0]                 bus_rdata
);
  import dmacc_pkg::*;
  logic [1:0]  wait_ff;
  logic [15:0] pat_ff;
  wire logic [7:0] byte_v = breq.addr[7:0] ^ 8'h5a;
  // Both lanes carry the byte so odd and even addresses look alike
  assign bus_done  = breq.valid && wait_ff == (slow ? 2'h3 : 2'h0);
  assign bus_rdata = bus_done && !breq.write ? {byte_v, byte_v} : pat_ff;
  // Idle data keeps moving so a stale sample never looks right
  always_ff @(posedge clk) begin
    if (rst) begin
      pat_ff <= 16'h0000;
    end else begin
      pat_ff <= pat_ff + 16'h3c5b;
    end
    if (rst || !breq.valid || bus_done) begin
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the DMA channel control block.
// Assumes the bus model answers reads with the address byte xor 5a.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dmacc_pkg::*;
  logic        clk, rst, ce, periph_req, slow, bus_done, busy, block_done;
  dmacc_reg_t  regs;
  dmacc_breq_t breq;
  logic [15:0] rdata, bus_rdata, got, c, s_org, d_org, s_cur, d_cur;
  logic [25:0] beats[$];
  int          num_errors, check_count, cycles, n;
  dmacc_channel dmacc_channel_i (.clk(clk), .rst(rst), .ce(ce),
    .regs(regs), .rdata(rdata), .periph_req(periph_req), .breq(breq),
    .bus_done(bus_done), .bus_rdata(bus_rdata), .busy(busy),
    .block_done(block_done));
  dmacc_bus_model dmacc_bus_model_i (.clk(clk), .rst(rst), .breq(breq),
    .slow(slow), .bus_done(bus_done), .bus_rdata(bus_rdata));
  // ****************
  // Clock, timeout, beat monitor
  // ****************
  always #25 clk = ~clk;
  // Every answered beat is logged as kind, address and low data byte
  always @(posedge clk) begin
    cycles++;
    if (breq.valid && bus_done) begin
      beats.push_back({breq.write, breq.dummy, breq.addr,
        breq.write ? breq.wdata[7:0] : bus_rdata[7:0]});
    end
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regs.addr <= a;
    regs.wdata <= d;
    regs.wr <= 1'b1;
    @(posedge clk);
    regs.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regs.addr <= a;
    regs.rd <= 1'b1;
    @(posedge clk);
    regs.rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  function automatic logic [15:0] step(input logic [15:0] p,
                                       input logic [1:0] m, input logic b);
    logic [15:0] st;
    st = b ? 16'h0001 : 16'h0002;
    if (m == 2'h1) return p + st;
    if (m == 2'h2) return p - st;
    return p;
  endfunction
  task automatic setup(input int cnt);
    s_org = 16'($urandom) & 16'hfffe;
    d_org = 16'($urandom) & 16'hfffe;
    s_cur = s_org;
    d_cur = d_org;
    wr(OFS_SRC, s_org);
    wr(OFS_DST, d_org);
    wr(OFS_CNT, 16'(cnt));
  endtask
  // Starts a block by trigger or peripheral request and checks its beats
  task automatic run(input logic trg);
    logic [25:0] e[$];
    logic [7:0]  v;
    int          k;
    beats.delete();
    wr(OFS_CTRL, c | (trg ? 16'h0101 : 16'h0001));
    if (!trg) begin
      periph_req <= 1'b1;
      @(posedge clk);
      periph_req <= 1'b0;
    end
    k = 0;
    while (block_done !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    check(32'(k < 300), 32'h1);
    repeat (3) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      v = s_cur[7:0] ^ 8'h5a;
      e.push_back({2'b00, s_cur, v});
      e.push_back({2'b10, d_cur, v});
      if (c[BIT_DUMMY]) e.push_back({2'b11, s_cur, v});
      s_cur = step(s_cur, c[7:6], c[1]);
      d_cur = step(d_cur, c[5:4], c[1]);
    end
    check(32'(beats.size()), 32'(e.size()));
    foreach (e[i]) check({6'h00, beats[i]}, {6'h00, e[i]});
    rd(OFS_SRC);
    check({16'h0000, got}, {16'h0000, s_cur});
    rd(OFS_DST);
    check({16'h0000, got}, {16'h0000, d_cur});
    rd(OFS_CTRL);
    check({16'h0000, got}, {16'h0000, (c | 16'h0001) & 16'h06ff});
    rd(OFS_CNT);
    check({16'h0000, got}, 32'h0);
    rd(OFS_STAT);
    check({16'h0000, got}, 32'h0002);
    $display("test done at %0t", $time);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    periph_req = 1'b0;
    slow = 1'b0;
    regs = '0;
    void'($urandom(32'h7723));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL);
    check({16'h0000, got}, 32'h0);
    rd(4'h9);
    check({16'h0000, got}, 32'h0);
    wr(OFS_CTRL, 16'he6fe);
    rd(OFS_CTRL);
    check({16'h0000, got}, 32'h06fe);
    for (int t = 0; t < 14; t++) begin
      c = 16'($urandom) & 16'h06fe;
      n = c[3] ? 1 + $urandom_range(3) : 1;
      slow <= 1'($urandom);
      setup(n);
      run(1'($urandom));
      if (c[3] && (c[9] || c[2])) begin
        if (c[9]) begin
          s_cur = s_org;
          d_cur = d_org;
        end
        run(1'b1);
      end
    end
    // Disabling mid-block must stop the channel with no further beats
    setup(8);
    slow <= 1'b1;
    wr(OFS_CTRL, 16'h0159);
    repeat (6) @(posedge clk);
    wr(OFS_CTRL, 16'h0058);
    repeat (3) @(posedge clk);
    beats.delete();
    repeat (20) @(posedge clk);
    check({31'h0, busy}, 32'h0);
    check(32'(beats.size()), 32'h0);
    $display("disable test done at %0t", $time);
    // With the clock enable low a control write must be ignored
    ce <= 1'b0;
    wr(OFS_CTRL, 16'h0001);
    ce <= 1'b1;
    rd(OFS_CTRL);
    check({16'h0000, got}, 32'h0058);
    $display("enable test done at %0t", $time);
    stop_test();
  end
endmodule
bind dmacc_channel dmacc_channel_properties dmacc_channel_properties_i (
  .clk(clk), .rst(rst), .ce(ce), .regs(regs), .rdata(rdata),
  .periph_req(periph_req), .breq(breq), .bus_done(bus_done),
  .bus_rdata(bus_rdata), .busy(busy), .block_done(block_done));
`default_nettype wire
